// ### inc/dssp_pkg.sv
// Function
// - Chip select high enables I2C; chip select low enables SPI.
// - First low chip select disables I2C until power-on reset.
// - I2C address is 111011 plus the level on serial data out.
// - I2C works in standard, fast and high speed modes.
// - I2C write stores each data byte at its paired register address.
// - I2C read returns one byte per master acknowledge, address incrementing.
// - SPI mode 00 or 11 chosen from clock level after chip select falls.
// - Configuration bit 0 set makes serial data in a two-way line.
// - In three-wire SPI serial data out stays high impedance.
// - SPI samples on rising clock edge, updates output on falling edge.
// - SPI transaction spans chip select low; clock steady at both edges.
// - SPI control byte: bit 7 direction, low seven bits register address.
// - SPI write applies every control and data pair until chip select rises.
// - SPI read sends one dummy byte, then data until chip select rises.
// - SPI read increments the register address after each data byte.
// - Configuration bit 1 enables I2C watchdog; bit 2 picks 1.25 or 40 ms.
package dssp_pkg;

  localparam logic [5:0] I2C_ADDR_HI    = 6'h3B;
  localparam int         SPI_RW_POS     = 7;
  localparam int         CFG_THREE_WIRE = 0;
  localparam int         CFG_WDT_EN     = 1;
  localparam int         CFG_WDT_LONG   = 2;
  localparam int         CFG_W          = 3;

  localparam longint CLK_MHZ       = 200;
  localparam longint WDT_SHORT_NS  = 1_250_000;
  localparam longint WDT_LONG_NS   = 40_000_000;
  localparam longint WDT_SHORT_CYC = WDT_SHORT_NS * CLK_MHZ / 1000;
  localparam longint WDT_LONG_CYC  = WDT_LONG_NS * CLK_MHZ / 1000;
  localparam int     WDT_W         = 23;

  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam logic [2:0] SYNC_RST_HI = 3'h7;

  typedef enum logic [4:0] {
    I_IDLE = 5'h01,
    I_RX   = 5'h02,
    I_ACK  = 5'h04,
    I_TX   = 5'h08,
    I_MACK = 5'h10
  } dssp_i2c_st_t;

  typedef enum logic [2:0] {
    K_ADDR = 3'h1,
    K_REG  = 3'h2,
    K_DATA = 3'h4
  } dssp_kind_t;

  typedef enum logic [3:0] {
    SP_CTRL   = 4'h1,
    SP_WDATA  = 4'h2,
    SP_RDUMMY = 4'h4,
    SP_RDATA  = 4'h8
  } dssp_spi_ph_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } dssp_wr_t;

  typedef struct packed {
    logic [2:0]       scl_s;
    logic [2:0]       sda_s;
    logic [2:0]       csn_s;
    logic [2:0]       sdo_s;
    logic [1:0]       wtg_s;
    logic [1:0]       rtg_s;
    logic             scl_f;
    logic             sda_f;
    logic             csn_f;
    logic             sdo_f;
    logic             wtg_seen;
    logic             rtg_seen;
    logic             lock;
    logic             mode11;
    dssp_i2c_st_t     ist;
    dssp_kind_t       kind;
    logic [3:0]       bitcnt;
    logic [7:0]       sh;
    logic [7:0]       ptr;
    logic             rw;
    logic             sda_oe;
    logic [WDT_W-1:0] wdt;
    dssp_wr_t         wr;
    logic             wr_stb;
    logic             rd_stb;
    logic [7:0]       rd_addr;
    logic [7:0]       rd_hold;
  } dssp_sys_t;

  typedef struct packed {
    logic [2:0]   bitcnt;
    logic [6:0]   sh;
    logic [6:0]   addr;
    dssp_spi_ph_t ph;
  } dssp_spi_fr_t;

  typedef struct packed {
    logic       wtg;
    logic       rtg;
    dssp_wr_t   wr;
    logic [6:0] raddr;
  } dssp_spi_ev_t;

  localparam dssp_sys_t SYS_RST = '{scl_s: SYNC_RST_HI, sda_s: SYNC_RST_HI, csn_s: SYNC_RST_HI,
                                    scl_f: 1'b1, sda_f: 1'b1, csn_f: 1'b1, ist: I_IDLE,
                                    kind: K_ADDR, default: '0};
  localparam dssp_spi_fr_t FR_RST = '{ph: SP_CTRL, default: '0};

endpackage

// ### design/dssp_port.sv
`timescale 1ns/1ps
module dssp_port #(
  parameter longint WDT_SHORT_CYCLES = dssp_pkg::WDT_SHORT_CYC,  // Short watchdog count
  parameter longint WDT_LONG_CYCLES  = dssp_pkg::WDT_LONG_CYC    // Long watchdog count
) (
  input  wire logic                      i_clk,             // System clock
  input  wire logic                      i_resetn,          // Power-on reset
  input  wire logic                      i_serial_clk,      // SPI clock / I2C SCL
  input  wire logic                      i_chip_select_n,   // Chip select
  input  wire logic                      i_serial_data_in,  // Data pin level
  output logic                           o_serial_data_out, // Data pin drive value
  output logic                           o_serial_data_oe,  // Data pin drive enable
  input  wire logic                      i_sdo_in,          // Out pin level, I2C address bit
  output logic                           o_sdo_out,         // Out pin drive value
  output logic                           o_sdo_oe,          // Out pin drive enable
  input  wire logic [dssp_pkg::CFG_W-1:0] i_interface_config, // Interface configuration
  output logic                           o_wr_strobe,       // Register write pulse
  output dssp_pkg::dssp_wr_t             o_wr,              // Register write address and data
  output logic                           o_rd_strobe,       // Register read pulse
  output logic [7:0]                     o_rd_addr,         // Register read address
  input  wire logic [7:0]                i_rd_data,         // Read data for o_rd_addr
  output logic                           o_i2c_enabled,     // I2C slave still usable
  output logic                           o_spi_mode11       // Last SPI frame in mode 11
);
  import dssp_pkg::*;

  dssp_sys_t        sys_r;
  dssp_sys_t        sys_nxt;
  dssp_spi_fr_t     fr_r;
  dssp_spi_fr_t     fr_nxt;
  dssp_spi_ev_t     ev_r;
  dssp_spi_ev_t     ev_nxt;
  logic [7:0]       tx_r;
  logic [7:0]       tx_nxt;
  logic [7:0]       byte_in;
  logic             spi_rst_n;
  logic             spi_drv;
  logic             rise;
  logic             fall;
  logic             start;
  logic             stop;
  logic             wdt_exp;
  logic [WDT_W-1:0] wdt_lim;

  // Three-stage sync; a change counts once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic f);
    return (s[1] == s[2]) ? s[2] : f;
  endfunction

  // Frame logic is cleared whenever chip select is high
  assign spi_rst_n = i_resetn & ~i_chip_select_n;
  assign byte_in   = {fr_r.sh, i_serial_data_in};

  // System-clock side: I2C slave, lock, crossings
  always_comb begin
    sys_nxt        = sys_r;
    sys_nxt.scl_s  = {sys_r.scl_s[1:0], i_serial_clk};
    sys_nxt.sda_s  = {sys_r.sda_s[1:0], i_serial_data_in};
    sys_nxt.csn_s  = {sys_r.csn_s[1:0], i_chip_select_n};
    sys_nxt.sdo_s  = {sys_r.sdo_s[1:0], i_sdo_in};
    sys_nxt.scl_f  = filt(sys_r.scl_s, sys_r.scl_f);
    sys_nxt.sda_f  = filt(sys_r.sda_s, sys_r.sda_f);
    sys_nxt.csn_f  = filt(sys_r.csn_s, sys_r.csn_f);
    sys_nxt.sdo_f  = filt(sys_r.sdo_s, sys_r.sdo_f);
    sys_nxt.wtg_s  = {sys_r.wtg_s[0], ev_r.wtg};
    sys_nxt.rtg_s  = {sys_r.rtg_s[0], ev_r.rtg};
    sys_nxt.wr_stb = 1'b0;
    sys_nxt.rd_stb = 1'b0;

    rise  = ~sys_r.scl_f & sys_nxt.scl_f;
    fall  = sys_r.scl_f & ~sys_nxt.scl_f;
    start = sys_r.scl_f & sys_nxt.scl_f & sys_r.sda_f & ~sys_nxt.sda_f;
    stop  = sys_r.scl_f & sys_nxt.scl_f & ~sys_r.sda_f & sys_nxt.sda_f;

    if (!sys_nxt.csn_f) begin
      sys_nxt.lock = 1'b1;
    end
    if (sys_r.csn_f && !sys_nxt.csn_f) begin
      sys_nxt.mode11 = sys_nxt.scl_f;
    end
    if (sys_r.rd_stb) begin
      sys_nxt.rd_hold = i_rd_data;
    end

    // SPI events handed over by toggles
    if (sys_r.wtg_s[1] != sys_r.wtg_seen) begin
      sys_nxt.wtg_seen = sys_r.wtg_s[1];
      sys_nxt.wr       = ev_r.wr;
      sys_nxt.wr_stb   = 1'b1;
    end
    if (sys_r.rtg_s[1] != sys_r.rtg_seen) begin
      sys_nxt.rtg_seen = sys_r.rtg_s[1];
      sys_nxt.rd_addr  = {1'b0, ev_r.raddr};
      sys_nxt.rd_stb   = 1'b1;
    end

    // Watchdog runs while a frame is open and SCL sits low
    wdt_lim     = i_interface_config[CFG_WDT_LONG] ? WDT_W'(WDT_LONG_CYCLES) : WDT_W'(WDT_SHORT_CYCLES);
    wdt_exp     = i_interface_config[CFG_WDT_EN] && (sys_r.wdt >= wdt_lim);
    sys_nxt.wdt = (sys_r.ist != I_IDLE && !sys_r.scl_f) ? sys_r.wdt + WDT_W'(1) : '0;

    if (sys_nxt.lock || stop || wdt_exp) begin
      sys_nxt.ist    = I_IDLE;
      sys_nxt.sda_oe = 1'b0;
    end else if (start) begin
      sys_nxt.ist    = I_RX;
      sys_nxt.kind   = K_ADDR;
      sys_nxt.bitcnt = 4'h0;
      sys_nxt.sda_oe = 1'b0;
    end else begin
      case (sys_r.ist)
        I_RX: begin
          if (rise) begin
            sys_nxt.sh     = {sys_r.sh[6:0], sys_nxt.sda_f};
            sys_nxt.bitcnt = sys_r.bitcnt + 4'h1;
          end else if (fall && sys_r.bitcnt == 4'h8) begin
            sys_nxt.ist    = I_ACK;
            sys_nxt.sda_oe = 1'b1;
            case (sys_r.kind)
              K_ADDR: begin
                if (sys_r.sh[7:1] == {I2C_ADDR_HI, sys_r.sdo_f}) begin
                  sys_nxt.rw   = sys_r.sh[0];
                  sys_nxt.kind = K_REG;
                end else begin
                  sys_nxt.ist    = I_IDLE;
                  sys_nxt.sda_oe = 1'b0;
                end
              end
              K_REG: begin
                sys_nxt.ptr  = sys_r.sh;
                sys_nxt.kind = K_DATA;
              end
              default: begin
                sys_nxt.wr     = '{addr: sys_r.ptr, data: sys_r.sh};
                sys_nxt.wr_stb = 1'b1;
                sys_nxt.kind   = K_REG;
              end
            endcase
          end
        end
        I_ACK: begin
          if (fall) begin
            sys_nxt.sda_oe = 1'b0;
            sys_nxt.bitcnt = 4'h0;
            if (sys_r.rw) begin
              sys_nxt.ist     = I_TX;
              sys_nxt.rd_stb  = 1'b1;
              sys_nxt.rd_addr = sys_r.ptr;
            end else begin
              sys_nxt.ist = I_RX;
            end
          end
        end
        I_TX: begin
          if (sys_r.rd_stb) begin
            sys_nxt.sh     = i_rd_data;
            sys_nxt.sda_oe = ~i_rd_data[7];
          end else if (fall) begin
            if (sys_r.bitcnt == 4'h7) begin
              sys_nxt.ist    = I_MACK;
              sys_nxt.sda_oe = 1'b0;
            end else begin
              sys_nxt.sh     = {sys_r.sh[6:0], 1'b0};
              sys_nxt.bitcnt = sys_r.bitcnt + 4'h1;
              sys_nxt.sda_oe = ~sys_r.sh[6];
            end
          end
        end
        I_MACK: begin
          if (rise) begin
            if (!sys_nxt.sda_f) begin
              sys_nxt.ist = I_ACK;
              sys_nxt.ptr = sys_r.ptr + 8'h01;
            end else begin
              sys_nxt.ist = I_IDLE;
            end
          end
        end
        default: begin
          sys_nxt.ist = I_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sys_r <= SYS_RST;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  // Link side: bytes shift in on rising SPI clock edges
  always_comb begin
    fr_nxt        = fr_r;
    ev_nxt        = ev_r;
    fr_nxt.sh     = byte_in[6:0];
    fr_nxt.bitcnt = fr_r.bitcnt + 3'h1;
    if (fr_r.bitcnt == 3'h7) begin
      case (fr_r.ph)
        SP_CTRL: begin
          fr_nxt.addr = byte_in[6:0];
          if (byte_in[SPI_RW_POS]) begin
            fr_nxt.ph    = SP_RDUMMY;
            ev_nxt.raddr = byte_in[6:0];
            ev_nxt.rtg   = ~ev_r.rtg;
          end else begin
            fr_nxt.ph = SP_WDATA;
          end
        end
        SP_WDATA: begin
          // Only whole bytes reach here, so a cut byte never writes
          ev_nxt.wr  = '{addr: {1'b0, fr_r.addr}, data: byte_in};
          ev_nxt.wtg = ~ev_r.wtg;
          fr_nxt.ph  = SP_CTRL;
        end
        SP_RDUMMY: begin
          fr_nxt.ph = SP_RDATA;
        end
        default: begin
          fr_nxt.ph = SP_RDATA;
        end
      endcase
    end else if (fr_r.bitcnt == 3'h0 && fr_r.ph == SP_RDATA) begin
      // Prefetch next byte a whole byte ahead of its use
      ev_nxt.raddr = ev_r.raddr + 7'h01;
      ev_nxt.rtg   = ~ev_r.rtg;
    end
  end

  always_ff @(posedge i_serial_clk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      fr_r <= FR_RST;
    end else begin
      fr_r <= fr_nxt;
    end
  end

  // Toggles survive chip select so no event is lost or invented
  always_ff @(posedge i_serial_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_r <= '0;
    end else begin
      ev_r <= ev_nxt;
    end
  end

  // rd_hold is stable for most of a byte before it is loaded here
  assign tx_nxt = (fr_r.bitcnt == 3'h0 && fr_r.ph == SP_RDATA) ? sys_r.rd_hold : {tx_r[6:0], 1'b0};

  always_ff @(negedge i_serial_clk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      tx_r <= BYTE_RST;
    end else begin
      tx_r <= tx_nxt;
    end
  end

  assign spi_drv           = ~i_chip_select_n & i_interface_config[CFG_THREE_WIRE]
                             & (fr_r.ph == SP_RDUMMY || fr_r.ph == SP_RDATA);
  assign o_serial_data_oe  = sys_r.sda_oe | spi_drv;
  assign o_serial_data_out = spi_drv & tx_r[7];
  assign o_sdo_oe          = ~i_chip_select_n & ~i_interface_config[CFG_THREE_WIRE];
  assign o_sdo_out         = tx_r[7];
  assign o_wr_strobe       = sys_r.wr_stb;
  assign o_wr              = sys_r.wr;
  assign o_rd_strobe       = sys_r.rd_stb;
  assign o_rd_addr         = sys_r.rd_addr;
  assign o_i2c_enabled     = ~sys_r.lock;
  assign o_spi_mode11      = sys_r.mode11;

  a_lock_sticky: assert property (@(posedge i_clk) disable iff (!i_resetn)
    sys_r.lock |=> sys_r.lock)
    else $error("I2C lock cleared without reset");

  a_lock_on_select: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !sys_r.csn_f |=> sys_r.lock ##1 (sys_r.ist == I_IDLE && !sys_r.sda_oe))
    else $error("I2C still active after chip select low");

  a_addr_match: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (sys_r.ist == I_RX && sys_r.kind == K_ADDR) ##1 (sys_r.ist == I_ACK)
    |-> $past(sys_r.sh[7:1]) == {I2C_ADDR_HI, $past(sys_r.sdo_f)})
    else $error("I2C acknowledged a foreign address");

  a_i2c_pair_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (sys_r.ist == I_RX && sys_r.kind == K_DATA) ##1 (sys_r.ist == I_ACK)
    |-> (o_wr_strobe && o_wr.addr == sys_r.ptr && o_wr.data == $past(sys_r.sh) && sys_r.kind == K_REG)
    ##1 !o_wr_strobe)
    else $error("I2C data byte not written at its address");

  a_i2c_rd_incr: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (sys_r.ist == I_MACK) ##1 (sys_r.ist == I_ACK) |-> sys_r.ptr == $past(sys_r.ptr) + 8'h01)
    else $error("I2C read address not incremented");

  a_i2c_tx_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (sys_r.ist == I_TX && sys_r.rd_stb) |=> sys_r.sh == $past(i_rd_data) && sys_r.sda_oe == ~$past(i_rd_data[7]))
    else $error("I2C read byte not loaded");

  a_wdt_release: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wdt_exp |=> sys_r.ist == I_IDLE && !sys_r.sda_oe)
    else $error("Watchdog expiry did not free the bus");

  a_sdo_three_wire: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_interface_config[CFG_THREE_WIRE] |-> !o_sdo_oe)
    else $error("Serial data out driven in three-wire mode");

  a_spi_bit_count: assert property (@(posedge i_serial_clk) disable iff (!spi_rst_n)
    fr_r.bitcnt == 3'h7 |=> fr_r.bitcnt == 3'h0 ##1 fr_r.bitcnt == 3'h1)
    else $error("SPI bit counter out of step");

  a_spi_ctrl_read: assert property (@(posedge i_serial_clk) disable iff (!spi_rst_n)
    (fr_r.bitcnt == 3'h7 && fr_r.ph == SP_CTRL && fr_r.sh[6])
    |=> fr_r.ph == SP_RDUMMY && ev_r.raddr == $past(byte_in[6:0]) && ev_r.rtg != $past(ev_r.rtg))
    else $error("SPI read control byte mishandled");

  a_spi_rd_incr: assert property (@(posedge i_serial_clk) disable iff (!spi_rst_n)
    (fr_r.bitcnt == 3'h0 && fr_r.ph == SP_RDATA) |=> ev_r.raddr == $past(ev_r.raddr) + 7'h01)
    else $error("SPI read address not incremented");

  a_spi_wr_pair: assert property (@(posedge i_serial_clk) disable iff (!spi_rst_n)
    (fr_r.bitcnt == 3'h7 && fr_r.ph == SP_WDATA)
    |=> ev_r.wr.data == $past(byte_in) && ev_r.wr.addr == {1'b0, $past(fr_r.addr)} && fr_r.ph == SP_CTRL)
    else $error("SPI write pair not captured");

endmodule

// ### verif/dssp_host.sv
`timescale 1ns/1ps
module dssp_host (
  input  wire logic i_line, // Data pin level
  input  wire logic i_sdo,  // Out pin level
  output logic      o_scl,  // Serial clock
  output logic      o_csn,  // Chip select
  output logic      o_val,  // Data drive value
  output logic      o_oe    // Data drive enable
);
  int   h = 150;
  logic m11;
  logic tw;
  initial begin
    o_scl = 1'b1;
    o_csn = 1'b1;
    o_val = 1'b0;
    o_oe  = 1'b0;
    m11   = 1'b0;
    tw    = 1'b0;
  end
  // Open drain: only ever pulls low
  task automatic i2c_bit(input logic b, output logic r);
    #(h/2) o_oe = ~b;
    #(h/2) o_scl = 1'b1;
    #(h/2) r = i_line;
    #(h/2) o_scl = 1'b0;
  endtask
  task automatic i2c_start;
    if (o_scl == 1'b0) begin
      #(h/2) o_oe = 1'b0;
      #(h/2) o_scl = 1'b1;
      #h;
    end
    o_oe = 1'b1;
    #h o_scl = 1'b0;
  endtask
  task automatic i2c_stop;
    #(h/2) o_oe = 1'b1;
    #(h/2) o_scl = 1'b1;
    #h o_oe = 1'b0;
    #h;
  endtask
  // Byte then acknowledge bit; last high releases the line
  task automatic i2c_byte(input logic [7:0] b, input logic last, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(b[i], r[i]);
    end
    i2c_bit(last, a);
  endtask
  task automatic cs_blip;
    o_csn = 1'b0;
    #100 o_csn = 1'b1;
    #100;
  endtask
  task automatic spi_begin(input logic mode11, input logic three);
    m11   = mode11;
    tw    = three;
    o_scl = mode11;
    #20 o_csn = 1'b0;
    #20;
  endtask
  // 32 ns clock within a byte, idle gap between bytes
  task automatic spi_byte(input logic [7:0] b, input int n, input logic drv, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      o_scl = 1'b0;
      o_oe  = drv;
      o_val = b[i];
      #16 o_scl = 1'b1;
      r[i] = tw ? i_line : i_sdo;
      #16;
    end
    if (!m11) begin
      o_scl = 1'b0;
    end
    #200;
  endtask
  task automatic spi_end;
    #20 o_csn = 1'b1;
    #20 o_oe = 1'b0;
    o_val = 1'b0;
  endtask
endmodule

// ### verif/dssp_port_tb_top.sv
`timescale 1ns/1ps
module dssp_port_tb_top;
  import dssp_pkg::*;
  localparam logic [7:0] AW = {I2C_ADDR_HI, 2'b10};
  localparam logic [7:0] AR = {I2C_ADDR_HI, 2'b11};
  logic             i_clk;
  logic             i_resetn;
  logic             strap;
  logic [CFG_W-1:0] cfg;
  logic             scl, csn, h_val, h_oe, sda, sdo;
  logic             dout, doe, sdo_out, sdo_oe, wr_stb, rd_stb, i2c_en, m11;
  dssp_wr_t         wr;
  logic [7:0]       rd_addr;
  logic [7:0]       regs [256];
  int               err_count, tests_run, wr_count, rd_count;
  assign sda = ~((doe & ~dout) | (h_oe & ~h_val));
  assign sdo = sdo_oe ? sdo_out : strap;
  dssp_port #(.WDT_SHORT_CYCLES(40), .WDT_LONG_CYCLES(80)) i_dssp_port (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_serial_clk(scl), .i_chip_select_n(csn),
    .i_serial_data_in(sda), .o_serial_data_out(dout), .o_serial_data_oe(doe), .i_sdo_in(sdo),
    .o_sdo_out(sdo_out), .o_sdo_oe(sdo_oe), .i_interface_config(cfg), .o_wr_strobe(wr_stb), .o_wr(wr),
    .o_rd_strobe(rd_stb), .o_rd_addr(rd_addr), .i_rd_data(regs[rd_addr]), .o_i2c_enabled(i2c_en),
    .o_spi_mode11(m11));
  dssp_host i_dssp_host (.i_line(sda), .i_sdo(sdo), .o_scl(scl), .o_csn(csn), .o_val(h_val), .o_oe(h_oe));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (wr_stb === 1'b1) begin
      regs[wr.addr] <= wr.data;
      wr_count <= wr_count + 1;
    end
    if (rd_stb === 1'b1) begin
      rd_count <= rd_count + 1;
    end
  end
  function automatic logic [7:0] pre(input int a);
    return 8'(a) ^ 8'h5A;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic do_reset;
    @(negedge i_clk) i_resetn = 1'b0;
    repeat (3) @(negedge i_clk);
    i_resetn = 1'b1;
    repeat (6) @(negedge i_clk);
  endtask
  task automatic wb(input logic [7:0] b);
    logic [7:0] r;
    logic       a;
    i_dssp_host.i2c_byte(b, 1'b1, r, a);
    chk(a, 1'b0);
  endtask
  task automatic t_i2c_addr;
    int         hs [3] = '{5000, 1250, 150};
    logic [7:0] r;
    logic       a;
    for (int k = 0; k < 3; k++) begin
      @(negedge i_clk) strap = k[0];
      i_dssp_host.h = hs[k];
      i_dssp_host.i2c_start();
      i_dssp_host.i2c_byte({I2C_ADDR_HI, k[0], 1'b0}, 1'b1, r, a);
      chk(a, 1'b0);
      i_dssp_host.i2c_stop();
    end
    i_dssp_host.i2c_start();
    i_dssp_host.i2c_byte({I2C_ADDR_HI, ~strap, 1'b0}, 1'b1, r, a);
    chk(a, 1'b1);
    i_dssp_host.i2c_stop();
  endtask
  task automatic t_i2c_write;
    int n0;
    n0 = wr_count;
    @(negedge i_clk) strap = 1'b1;
    i_dssp_host.i2c_start();
    wb(AW);
    wb(8'h12);
    wb(8'hC3);
    wb(8'h13);
    wb(8'h3C);
    wb(8'h14);
    i_dssp_host.i2c_stop();
    repeat (10) @(negedge i_clk);
    chk(regs[8'h12], 8'hC3);
    chk(regs[8'h13], 8'h3C);
    chk(8'(wr_count - n0), 8'd2);
  endtask
  task automatic t_i2c_read;
    logic [7:0] r;
    logic       a;
    int         n0;
    n0 = rd_count;
    i_dssp_host.i2c_start();
    wb(AW);
    wb(8'h30);
    i_dssp_host.i2c_start();
    wb(AR);
    for (int i = 0; i < 3; i++) begin
      i_dssp_host.i2c_byte(8'hFF, i == 2, r, a);
      chk(r, pre(8'h30 + i));
    end
    i_dssp_host.i2c_stop();
    chk(8'(rd_count - n0), 8'd3);
  endtask
  task automatic t_wdt;
    logic r;
    for (int k = 0; k < 2; k++) begin
      @(negedge i_clk) cfg = {k[0], 1'b1, 1'b0};
      i_dssp_host.i2c_start();
      for (int i = 7; i >= 0; i--) begin
        i_dssp_host.i2c_bit(AW[i], r);
      end
      repeat (60) @(negedge i_clk);
      chk(doe, k[0]);
      repeat (40) @(negedge i_clk);
      chk(doe, 1'b0);
      i_dssp_host.i2c_stop();
    end
    @(negedge i_clk) cfg = '0;
  endtask
  task automatic t_lock;
    logic [7:0] r;
    logic       a;
    chk(i2c_en, 1'b1);
    i_dssp_host.cs_blip();
    repeat (5) @(negedge i_clk);
    chk(i2c_en, 1'b0);
    i_dssp_host.i2c_start();
    i_dssp_host.i2c_byte(AW, 1'b1, r, a);
    chk(a, 1'b1);
    i_dssp_host.i2c_stop();
  endtask
  task automatic t_spi_write;
    logic [7:0] r;
    int         n0;
    n0 = wr_count;
    i_dssp_host.spi_begin(1'b0, 1'b0);
    i_dssp_host.spi_byte(8'h05, 8, 1'b1, r);
    i_dssp_host.spi_byte(8'hAB, 8, 1'b1, r);
    i_dssp_host.spi_byte(8'h7F, 8, 1'b1, r);
    i_dssp_host.spi_byte(8'h11, 8, 1'b1, r);
    i_dssp_host.spi_byte(8'h06, 8, 1'b1, r);
    i_dssp_host.spi_byte(8'hFF, 4, 1'b1, r);
    i_dssp_host.spi_end();
    repeat (10) @(negedge i_clk);
    chk(regs[8'h05], 8'hAB);
    chk(regs[8'h7F], 8'h11);
    chk(regs[8'h06], pre(6));
    chk(8'(wr_count - n0), 8'd2);
    chk(m11, 1'b0);
  endtask
  task automatic t_spi_read;
    logic [7:0] r;
    i_dssp_host.spi_begin(1'b1, 1'b0);
    i_dssp_host.spi_byte(8'hFE, 8, 1'b1, r);
    i_dssp_host.spi_byte(8'h00, 8, 1'b1, r);
    i_dssp_host.spi_byte(8'h00, 8, 1'b1, r);
    chk(r, pre(8'h7E));
    i_dssp_host.spi_byte(8'h00, 8, 1'b1, r);
    chk(r, 8'h11);
    i_dssp_host.spi_byte(8'h00, 8, 1'b1, r);
    chk(r, pre(0));
    i_dssp_host.spi_end();
    chk(m11, 1'b1);
  endtask
  task automatic t_spi_3w;
    logic [7:0] r;
    @(negedge i_clk) cfg = 3'h1;
    i_dssp_host.spi_begin(1'b0, 1'b1);
    i_dssp_host.spi_byte(8'h85, 8, 1'b1, r);
    i_dssp_host.spi_byte(8'h00, 8, 1'b0, r);
    chk(sdo_oe, 1'b0);
    i_dssp_host.spi_byte(8'h00, 8, 1'b0, r);
    chk(r, 8'hAB);
    i_dssp_host.spi_end();
    @(negedge i_clk) cfg = '0;
  endtask
  initial begin
    i_resetn  = 1'b0;
    cfg       = '0;
    strap     = 1'b0;
    err_count = 0;
    tests_run = 0;
    wr_count  = 0;
    rd_count  = 0;
    for (int i = 0; i < 256; i++) begin
      regs[i] = pre(i);
    end
    do_reset();
    t_i2c_addr();
    t_i2c_write();
    t_i2c_read();
    t_wdt();
    t_lock();
    t_spi_write();
    t_spi_read();
    t_spi_3w();
    do_reset();
    chk(i2c_en, 1'b1);
    report_and_stop();
  end
  initial begin
    repeat (95000) @(posedge i_clk);
    err_count++;
    report_and_stop();
  end
endmodule
